// ### hw/usmp_pkg.sv
// Package for the UART serial and modem pin logic: offsets, fields, resets, states.
package usmp_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_MODEM_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FEATURE_CTRL = 8'h04;
  localparam logic [7:0] OFF_ENH_FEATURE  = 8'h08;
  localparam logic [7:0] OFF_INT_ENABLE   = 8'h0c;
  localparam logic [7:0] OFF_ALT_FUNC     = 8'h10;
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h14;
  localparam logic [7:0] OFF_TX_DATA      = 8'h18;
  localparam logic [7:0] OFF_RX_DATA      = 8'h1c;
  localparam logic [7:0] OFF_BAUD_DIV     = 8'h20;

  // Field positions
  localparam int MC_DTR_BIT      = 0;
  localparam int MC_RTS_BIT      = 1;
  localparam int MC_USER_BIT     = 3;
  localparam int MC_IR_BIT       = 6;
  localparam int FC_RXINV_BIT    = 2;
  localparam int FC_RS485_BIT    = 3;
  localparam int EF_AUTORTS_BIT  = 6;
  localparam int EF_AUTOCTS_BIT  = 7;
  localparam int IE_AUTORTS_BIT  = 6;
  localparam int IE_AUTOCTS_BIT  = 7;
  localparam int AF_SEL_LSB      = 1;
  localparam int ST_CTS_BIT      = 0;
  localparam int ST_DSR_BIT      = 1;
  localparam int ST_CD_BIT       = 2;
  localparam int ST_RI_BIT       = 3;
  localparam int ST_RXLINE_BIT   = 4;
  localparam int ST_TXBUSY_BIT   = 5;
  localparam int ST_RXRDY_BIT    = 6;

  // Multi-function output selections
  localparam logic [1:0] FN_USER  = 2'h0;
  localparam logic [1:0] FN_BAUD  = 2'h1;
  localparam logic [1:0] FN_RXRDY = 2'h2;

  // Reset values
  localparam logic [7:0]  MC_RST   = 8'h00;
  localparam logic [7:0]  FC_RST   = 8'h00;
  localparam logic [7:0]  EF_RST   = 8'h00;
  localparam logic [7:0]  IE_RST   = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;

  // Timing counts in 16x ticks; BIT_LAST counts data bits
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] IR_PULSE  = 4'h3;
  localparam logic [3:0] RX_MID    = 4'h7;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // Serial state machine, one-hot
  typedef enum logic [3:0] {
    USMP_IDLE  = 4'b0001,
    USMP_START = 4'b0010,
    USMP_DATA  = 4'b0100,
    USMP_STOP  = 4'b1000
  } usmp_state_e;

endpackage

// ### hw/usmp_pin_logic.sv
// UART channel serial, infrared and modem pin logic with APB registers.
//
// Notes on behaviour
// - Infrared receive idles low, optional inversion
// - Mode bit clear selects standard serial
// - Standard transmit high in reset and idle
// - Mode bit set routes through infrared codec
// - Infrared transmit held low when idle
// - Request-to-send low-active, manual or automatic
// - Request-to-send may drive half-duplex direction
// - Clear-to-send readable, may gate transmit
// - Terminal-ready low-active general output
// - Modem status inputs low-active, readable
// - Multi-function pin shows one chosen function
// - User function: pin low when bit set
// - User bit cleared by every reset
// - Baud function: pin shows 16x clock for divisors above one, stays high at divisor one
// - Receive-ready function: low-active data flag
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module usmp_pin_logic #(
  parameter logic [1:0] FN_RESET_SEL = usmp_pkg::FN_USER,
  parameter int         DIV_W        = 16
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Serial pins
  input  wire logic        serial_in_ch_a,
  output var  logic        serial_out_ch_a,
  // Modem pins
  output var  logic        request_send_n_ch_a,
  input  wire logic        clear_send_n_ch_a,
  output var  logic        terminal_ready_n_ch_a,
  input  wire logic        set_ready_n_ch_a,
  input  wire logic        carrier_detect_n_ch_a,
  input  wire logic        ring_indicator_n_ch_a,
  output var  logic        multi_function_out_n_ch_a
);
  import usmp_pkg::*;

  logic [7:0]       modem_control_reg_q;
  logic [7:0]       feature_control_reg_q;
  logic [7:0]       enhanced_feature_reg_q;
  logic [7:0]       interrupt_enable_reg_q;
  logic [1:0]       fn_sel_q;
  logic [DIV_W-1:0] baud_div_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic             tick_q;
  logic             baud_clk_q;
  logic [3:0]       modem_in_q;
  logic [7:0]       tx_hold_q;
  logic             tx_pend_q;
  usmp_state_e      tx_state_q;
  logic [3:0]       tx_sub_q;
  logic [2:0]       tx_bit_q;
  logic [7:0]       tx_shift_q;
  usmp_state_e      rx_state_q;
  logic [3:0]       rx_sub_q;
  logic [2:0]       rx_bit_q;
  logic [7:0]       rx_shift_q;
  logic [7:0]       rx_data_q;
  logic             rx_ready_q;
  logic [3:0]       ir_stretch_q;
  logic             rx_line_q;

  logic       ir_mode;
  logic       wr_en;
  logic       rd_setup;
  logic       tx_level;
  logic       auto_rts;
  logic       auto_cts;
  logic       tx_busy;
  logic       ir_pulse;
  logic       rx_done;
  logic [7:0] status;
  logic       fn_d;
  logic       rts_d;

  // Register hit for a given offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Known offset check, also drives the error answer
  function automatic logic mapped(input logic [7:0] a);
    return hit(a, OFF_MODEM_CTRL) || hit(a, OFF_FEATURE_CTRL) || hit(a, OFF_ENH_FEATURE) ||
           hit(a, OFF_INT_ENABLE) || hit(a, OFF_ALT_FUNC) || hit(a, OFF_MODEM_STATUS) ||
           hit(a, OFF_TX_DATA) || hit(a, OFF_RX_DATA) || hit(a, OFF_BAUD_DIV);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and shared terms
  assign wr_en    = psel && penable && pwrite && mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign ir_mode  = modem_control_reg_q[MC_IR_BIT];
  assign auto_rts = enhanced_feature_reg_q[EF_AUTORTS_BIT] && interrupt_enable_reg_q[IE_AUTORTS_BIT];
  assign auto_cts = enhanced_feature_reg_q[EF_AUTOCTS_BIT] && interrupt_enable_reg_q[IE_AUTOCTS_BIT];
  assign tx_busy  = tx_state_q != USMP_IDLE;
  assign rx_done  = tick_q && rx_state_q == USMP_STOP && rx_sub_q == RX_MID;
  // Status in asserted-high sense; raw pins stay low-active
  assign status   = {1'b0, rx_ready_q, tx_busy, rx_line_q, ~modem_in_q};

  // Configuration registers; user bit cleared on reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      modem_control_reg_q    <= MC_RST;
      feature_control_reg_q  <= FC_RST;
      enhanced_feature_reg_q <= EF_RST;
      interrupt_enable_reg_q <= IE_RST;
      fn_sel_q               <= FN_RESET_SEL;
      baud_div_q             <= DIV_W'(DIV_RST);
    end else if (wr_en) begin
      if (hit(paddr, OFF_MODEM_CTRL)) modem_control_reg_q <= pwdata[7:0];
      if (hit(paddr, OFF_FEATURE_CTRL)) feature_control_reg_q <= pwdata[7:0];
      if (hit(paddr, OFF_ENH_FEATURE)) enhanced_feature_reg_q <= pwdata[7:0];
      if (hit(paddr, OFF_INT_ENABLE)) interrupt_enable_reg_q <= pwdata[7:0];
      if (hit(paddr, OFF_ALT_FUNC)) fn_sel_q <= pwdata[AF_SEL_LSB +: 2];
      if (hit(paddr, OFF_BAUD_DIV)) baud_div_q <= pwdata[DIV_W-1:0];
    end
  end

  // Read data and error captured in setup, so the answer is a flop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= !mapped(paddr);
        prdata  <= 32'h0000_0000;
        if (rd_setup) begin
          case (1'b1)
            hit(paddr, OFF_MODEM_CTRL):   prdata[7:0] <= modem_control_reg_q;
            hit(paddr, OFF_FEATURE_CTRL): prdata[7:0] <= feature_control_reg_q;
            hit(paddr, OFF_ENH_FEATURE):  prdata[7:0] <= enhanced_feature_reg_q;
            hit(paddr, OFF_INT_ENABLE):   prdata[7:0] <= interrupt_enable_reg_q;
            hit(paddr, OFF_ALT_FUNC):     prdata[7:0] <= {5'h00, fn_sel_q, 1'b0};
            hit(paddr, OFF_MODEM_STATUS): prdata[7:0] <= status;
            hit(paddr, OFF_TX_DATA):      prdata[7:0] <= tx_hold_q;
            hit(paddr, OFF_RX_DATA):      prdata[7:0] <= rx_data_q;
            hit(paddr, OFF_BAUD_DIV):     prdata[DIV_W-1:0] <= baud_div_q;
            default:                      prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16x tick and 16x clock, high for the lower half of the count, never high at divisor one; divisor zero acts as one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q  <= '0;
      tick_q     <= 1'b0;
      baud_clk_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (div_cnt_q + DIV_W'(1) >= baud_div_q) begin
        div_cnt_q <= '0;
        tick_q    <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + DIV_W'(1);
      end
      baud_clk_q <= div_cnt_q < (baud_div_q >> 1);
    end
  end

  // Modem inputs sampled; pins taken as synchronous
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) modem_in_q <= 4'hf;
    else modem_in_q <= {ring_indicator_n_ch_a, carrier_detect_n_ch_a, set_ready_n_ch_a, clear_send_n_ch_a};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding byte; a write while full is dropped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end else if (wr_en && hit(paddr, OFF_TX_DATA) && !tx_pend_q) begin
      tx_hold_q <= pwdata[7:0];
      tx_pend_q <= 1'b1;
    end else if (tx_state_q == USMP_IDLE && tx_pend_q && tick_q && !(auto_cts && clear_send_n_ch_a)) begin
      tx_pend_q <= 1'b0;
    end
  end

  // Transmit framer, 8N1, 16 ticks a bit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q <= USMP_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= 8'h00;
    end else if (tick_q) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      case (tx_state_q)
        USMP_IDLE: begin
          tx_sub_q <= 4'h0;
          if (tx_pend_q && !(auto_cts && clear_send_n_ch_a)) begin
            tx_state_q <= USMP_START;
            tx_shift_q <= tx_hold_q;
          end
        end
        USMP_START: begin
          if (tx_sub_q == TICK_LAST) tx_state_q <= USMP_DATA;
        end
        USMP_DATA: begin
          if (tx_sub_q == TICK_LAST) begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q   <= tx_bit_q + 3'h1;
            if (tx_bit_q == BIT_LAST) tx_state_q <= USMP_STOP;
          end
        end
        USMP_STOP: begin
          if (tx_sub_q == TICK_LAST) tx_state_q <= USMP_IDLE;
        end
        default: tx_state_q <= USMP_IDLE;
      endcase
    end
  end

  // Bit on the line; infrared sends a short high pulse per zero bit
  always_comb begin
    case (tx_state_q)
      USMP_START: tx_level = 1'b0;
      USMP_DATA:  tx_level = tx_shift_q[0];
      default:    tx_level = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) serial_out_ch_a <= 1'b1;
    else if (ir_mode) serial_out_ch_a <= !tx_level && tx_sub_q < IR_PULSE;
    else serial_out_ch_a <= tx_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared decode: pulse, after optional inversion, stretched over a bit
  assign ir_pulse = serial_in_ch_a ^ feature_control_reg_q[FC_RXINV_BIT];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) ir_stretch_q <= 4'h0;
    else if (ir_pulse) ir_stretch_q <= TICK_LAST;
    else if (tick_q && ir_stretch_q != 4'h0) ir_stretch_q <= ir_stretch_q - 4'h1;
  end

  // Receive line after mode routing; standard input must idle high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rx_line_q <= 1'b1;
    else if (ir_mode) rx_line_q <= !(ir_pulse || ir_stretch_q != 4'h0);
    else rx_line_q <= serial_in_ch_a;
  end

  // Receive framer, samples at mid-bit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q <= USMP_IDLE;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
    end else if (tick_q) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_state_q)
        USMP_IDLE: begin
          rx_sub_q <= 4'h0;
          if (!rx_line_q) rx_state_q <= USMP_START;
        end
        USMP_START: begin
          if (rx_sub_q == RX_MID) begin
            rx_sub_q   <= 4'h0;
            rx_bit_q   <= 3'h0;
            rx_state_q <= rx_line_q ? USMP_IDLE : USMP_DATA;
          end
        end
        USMP_DATA: begin
          if (rx_sub_q == TICK_LAST) begin
            rx_shift_q <= {rx_line_q, rx_shift_q[7:1]};
            rx_bit_q   <= rx_bit_q + 3'h1;
            if (rx_bit_q == BIT_LAST) rx_state_q <= USMP_STOP;
          end
        end
        USMP_STOP: begin
          if (rx_sub_q == RX_MID) rx_state_q <= USMP_IDLE;
        end
        default: rx_state_q <= USMP_IDLE;
      endcase
    end
  end

  // Received byte and ready flag; a new byte wins over the read clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_q  <= 8'h00;
      rx_ready_q <= 1'b0;
    end else if (rx_done) begin
      rx_data_q  <= rx_shift_q;
      rx_ready_q <= 1'b1;
    end else if (psel && penable && !pwrite && hit(paddr, OFF_RX_DATA)) begin
      rx_ready_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem outputs; manual bits are low-active, auto modes override
  always_comb begin
    if (feature_control_reg_q[FC_RS485_BIT]) rts_d = !(tx_busy || tx_pend_q);
    else if (auto_rts) rts_d = !modem_control_reg_q[MC_RTS_BIT] || rx_ready_q;
    else rts_d = !modem_control_reg_q[MC_RTS_BIT];
    case (fn_sel_q)
      FN_BAUD:  fn_d = !baud_clk_q;
      FN_RXRDY: fn_d = !rx_ready_q;
      default:  fn_d = !modem_control_reg_q[MC_USER_BIT];
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      request_send_n_ch_a       <= 1'b1;
      terminal_ready_n_ch_a     <= 1'b1;
      multi_function_out_n_ch_a <= 1'b1;
    end else begin
      request_send_n_ch_a       <= rts_d;
      terminal_ready_n_ch_a     <= !modem_control_reg_q[MC_DTR_BIT];
      multi_function_out_n_ch_a <= fn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence tx_quiet_s;
    tx_state_q == USMP_IDLE [*2];
  endsequence

  std_idle_high_a: assert property (tx_quiet_s ##0 !ir_mode [*2] |-> serial_out_ch_a)
    else $error("standard transmit not high while idle");
  ir_idle_low_a: assert property (tx_quiet_s ##0 ir_mode [*2] |-> !serial_out_ch_a)
    else $error("infrared transmit not low while idle");
  fn_user_pin_a: assert property ($stable(fn_sel_q) && fn_sel_q == FN_USER
      |=> multi_function_out_n_ch_a == !$past(modem_control_reg_q[MC_USER_BIT]))
    else $error("user function pin wrong");
  fn_rxrdy_pin_a: assert property (fn_sel_q == FN_RXRDY |=> multi_function_out_n_ch_a == !$past(rx_ready_q))
    else $error("receive-ready pin wrong");
  dtr_follows_a: assert property ($rose(modem_control_reg_q[MC_DTR_BIT]) |=> !terminal_ready_n_ch_a)
    else $error("terminal-ready not asserted");
  rts_manual_a: assert property (!auto_rts && !feature_control_reg_q[FC_RS485_BIT]
      |=> request_send_n_ch_a == !$past(modem_control_reg_q[MC_RTS_BIT]))
    else $error("request-to-send wrong");
  rs485_dir_a: assert property (feature_control_reg_q[FC_RS485_BIT] && tx_busy |=> !request_send_n_ch_a)
    else $error("direction not driven while sending");
  cts_gate_a: assert property (auto_cts && clear_send_n_ch_a && tx_state_q == USMP_IDLE
      |=> tx_state_q == USMP_IDLE)
    else $error("transmit started without clear-to-send");
  rx_flag_set_a: assert property (rx_done |=> rx_ready_q ##0 rx_data_q == $past(rx_shift_q))
    else $error("received byte not flagged");
endmodule
`default_nettype wire

// ### testbench/usmp_remote.sv
// Remote serial transceiver and modem model facing the channel pins.
`timescale 1ns/1ps
`default_nettype none
module usmp_remote (
  // Clock
  input  wire logic ref_clk,
  // Serial lines
  output var  logic line_to_dut,
  input  wire logic line_from_dut,
  // Modem status lines, all low-active
  output var  logic clear_send_n,
  output var  logic set_ready_n,
  output var  logic carrier_detect_n,
  output var  logic ring_indicator_n
);
  ////////////////////////////////////////////////////////////////////////////
  // Line idles high, modem lines released like unused pins tied to supply
  initial begin
    line_to_dut = 1'b1;
    {clear_send_n, set_ready_n, carrier_detect_n, ring_indicator_n} = 4'hf;
  end

  // Modem lines change just after an edge, order cts, dsr, cd, ri
  task automatic set_modem(input logic [3:0] v);
    @(posedge ref_clk);
    {clear_send_n, set_ready_n, carrier_detect_n, ring_indicator_n} <= v;
  endtask

  // Idle level for the mode in use
  task automatic idle(input logic v);
    @(posedge ref_clk);
    line_to_dut <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One 8N1 frame at divisor 1; infrared zero is a 3 clock pulse
  task automatic send(input logic [7:0] b, input logic ir, input logic inv);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge ref_clk);
        line_to_dut <= ir ? (inv ^ (!f[i] && t < 3)) : f[i];
      end
    end
  endtask

  // Capture a frame; infrared windows straddle the pulse so its phase is free
  task automatic recv(input logic ir, output logic [7:0] b, output logic ok);
    int   n;
    logic s;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    while (line_from_dut !== ir && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) return;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      s = 1'b0;
      for (int t = 0; t < 16; t++) begin
        @(posedge ref_clk);
        if (ir) s = s | line_from_dut;
        else if (t == 15) s = line_from_dut;
      end
      if (i < 8) b[i] = ir ? !s : s;
      else ok = ir ? !s : s;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the serial, infrared and modem pin logic.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usmp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ser_in, ser_out, rts_n, cts_n, dtr_n, dsr_n, cd_n, ri_n, multi_n;
  int          error_cnt = 0;
  int          compares = 0;
  int          k;
  logic [7:0]  b;
  logic        ok, err;
  logic [31:0] r;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  usmp_pin_logic u_usmp_pin_logic (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_ch_a(ser_in), .serial_out_ch_a(ser_out), .request_send_n_ch_a(rts_n),
    .clear_send_n_ch_a(cts_n), .terminal_ready_n_ch_a(dtr_n), .set_ready_n_ch_a(dsr_n),
    .carrier_detect_n_ch_a(cd_n), .ring_indicator_n_ch_a(ri_n), .multi_function_out_n_ch_a(multi_n));

  usmp_remote u_usmp_remote (.ref_clk(ref_clk), .line_to_dut(ser_in), .line_from_dut(ser_out),
    .clear_send_n(cts_n), .set_ready_n(dsr_n), .carrier_detect_n(cd_n), .ring_indicator_n(ri_n));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // APB transfer; waits on pready, never assumes a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin
      error_cnt++;
      finish_test;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        x;
    apb(1'b1, a, d, q, x);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        x;
    apb(1'b0, a, 32'h0, d, x);
    chk(n, e, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Guard against a hang anywhere in the run
  initial begin
    cyc(60000);
    chk("watchdog", 0, 1);
    finish_test;
  end

  // Main sequence
  initial begin
    cyc(2);
    chk("tx_rst", 1, ser_out);
    chk("multi_rst", 1, multi_n);
    chk("rdy_rst", 0, pready);
    chk("rts_rst", 1, rts_n);
    chk("dtr_rst", 1, dtr_n);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(2);
    rdc("mcr", OFF_MODEM_CTRL, 0);
    rdc("feature_control_reg", OFF_FEATURE_CTRL, 0);
    rdc("efr", OFF_ENH_FEATURE, 0);
    rdc("ier", OFF_INT_ENABLE, 0);
    rdc("afr", OFF_ALT_FUNC, 32'(FN_USER) << AF_SEL_LSB);
    rdc("div", OFF_BAUD_DIV, 1);
    // Unmapped place: error, write lost, reads zero
    wr(8'h24, 32'hffff_ffff);
    apb(1'b0, 8'h24, 32'h0, r, ok);
    chk("bad_err", 1, ok);
    chk("bad_rd", 0, r);
    // General purpose outputs
    wr(OFF_MODEM_CTRL, 32'h0b);
    cyc(2);
    chk("dtr", 0, dtr_n);
    chk("rts", 0, rts_n);
    chk("multi_user", 0, multi_n);
    // Fourth select code also shows the user bit
    wr(OFF_ALT_FUNC, 32'(2'h3) << AF_SEL_LSB);
    cyc(2);
    chk("multi_user3", 0, multi_n);
    wr(OFF_MODEM_CTRL, 32'h0);
    cyc(2);
    chk("multi_user", 1, multi_n);
    // Modem inputs read as inverted status, one clock late
    for (k = 0; k < 16; k += 5) begin
      u_usmp_remote.set_modem(k[3:0]);
      cyc(2);
      apb(1'b0, OFF_MODEM_STATUS, 32'h0, r, ok);
      chk("modem", {~k[0], ~k[1], ~k[2], ~k[3]}, r[3:0]);
    end
    // Standard transmit with half-duplex direction output
    wr(OFF_FEATURE_CTRL, 32'h08);
    fork
      u_usmp_remote.recv(1'b0, b, ok);
      wr(OFF_TX_DATA, 32'ha5);
      begin
        cyc(40);
        chk("rs485", 0, rts_n);
        apb(1'b0, OFF_MODEM_STATUS, 32'h0, r, err);
        chk("tx_busy", 1, r[ST_TXBUSY_BIT]);
      end
    join
    chk("tx_std", 8'ha5, b);
    chk("tx_stop", 1, ok);
    cyc(16);
    chk("tx_idle", 1, ser_out);
    chk("rs485", 1, rts_n);
    wr(OFF_FEATURE_CTRL, 32'h0);
    // Auto clear-to-send holds the byte until the remote allows it
    wr(OFF_ENH_FEATURE, 32'h80);
    wr(OFF_INT_ENABLE, 32'h80);
    wr(OFF_TX_DATA, 32'h3c);
    k = 0;
    repeat (100) begin
      @(posedge ref_clk);
      if (ser_out !== 1'b1) k++;
    end
    chk("cts_hold", 0, k);
    fork
      u_usmp_remote.recv(1'b0, b, ok);
      u_usmp_remote.set_modem(4'h7);
    join
    chk("tx_cts", 8'h3c, b);
    cyc(16);
    u_usmp_remote.set_modem(4'hf);
    // Receive, receive-ready function and auto request-to-send
    wr(OFF_ALT_FUNC, 32'(FN_RXRDY) << AF_SEL_LSB);
    wr(OFF_MODEM_CTRL, 32'h02);
    wr(OFF_ENH_FEATURE, 32'h40);
    wr(OFF_INT_ENABLE, 32'h40);
    cyc(2);
    chk("multi_rxrdy", 1, multi_n);
    chk("rts", 0, rts_n);
    u_usmp_remote.send(8'h96, 1'b0, 1'b0);
    cyc(2);
    chk("multi_rxrdy", 0, multi_n);
    chk("auto_rts", 1, rts_n);
    apb(1'b0, OFF_MODEM_STATUS, 32'h0, r, ok);
    chk("rx_flag", 1, r[ST_RXRDY_BIT]);
    rdc("rx_std", OFF_RX_DATA, 32'h96);
    cyc(2);
    chk("multi_rxrdy", 1, multi_n);
    chk("auto_rts", 0, rts_n);
    // Baud function: one rise per divisor period
    wr(OFF_ALT_FUNC, 32'(FN_BAUD) << AF_SEL_LSB);
    wr(OFF_BAUD_DIV, 32'h4);
    cyc(4);
    k = 0;
    ok = multi_n;
    repeat (64) begin
      @(posedge ref_clk);
      if (multi_n === 1'b1 && ok === 1'b0) k++;
      ok = multi_n;
    end
    chk("baud_x16", 16, k);
    wr(OFF_BAUD_DIV, 32'h1);
    wr(OFF_ALT_FUNC, 32'h0);
    // Infrared mode; the level swap may leave a stray byte, drained here
    wr(OFF_MODEM_CTRL, 32'h40);
    u_usmp_remote.idle(1'b0);
    cyc(200);
    apb(1'b0, OFF_RX_DATA, 32'h0, r, ok);
    chk("ir_idle", 0, ser_out);
    apb(1'b0, OFF_MODEM_STATUS, 32'h0, r, err);
    chk("ir_rx_idle", 1, r[ST_RXLINE_BIT]);
    fork
      u_usmp_remote.recv(1'b1, b, ok);
      wr(OFF_TX_DATA, 32'h5a);
    join
    chk("tx_ir", 8'h5a, b);
    chk("ir_stop", 1, ok);
    cyc(16);
    chk("ir_idle", 0, ser_out);
    u_usmp_remote.send(8'hc3, 1'b1, 1'b0);
    cyc(2);
    rdc("rx_ir", OFF_RX_DATA, 32'hc3);
    // Inverted infrared receive pulses
    wr(OFF_FEATURE_CTRL, 32'h04);
    u_usmp_remote.idle(1'b1);
    cyc(200);
    apb(1'b0, OFF_RX_DATA, 32'h0, r, ok);
    u_usmp_remote.send(8'h81, 1'b1, 1'b1);
    cyc(2);
    rdc("rx_irinv", OFF_RX_DATA, 32'h81);
    finish_test;
  end
endmodule
`default_nettype wire
